// *** include/host_port_pkg.sv ***
// Purpose: shared constants, request/response carriers and states of the
//          host access port
// Assumes: long-word host addressing, four byte lanes of 8 bits
// Notes:   the pin vector packs select, read, write, byte selects, address
package host_port_pkg;

    // host address pin range; the local multiplexed bus carries it from bit 0
    localparam int ADDR_LSB = 5;
    localparam int ADDR_MSB = 31;
    localparam int ADDR_W = ADDR_MSB - ADDR_LSB + 1;
    localparam int BS_W = 4;
    localparam int BYTE_W = 8;
    localparam int DATA_W = BS_W * BYTE_W;
    localparam int FIFO_DEPTH = 16;

    // synchronised pin vector layout, strobes at the top
    localparam int PIN_W = 3 + BS_W + ADDR_W;
    localparam int SEL_BIT = PIN_W - 1;
    localparam int RD_BIT = PIN_W - 2;
    localparam int WR_BIT = PIN_W - 3;
    localparam int BS_LSB = ADDR_W;
    // strobes idle high, address and byte selects idle low
    localparam logic [PIN_W-1:0] PIN_IDLE = {3'h7, {(BS_W + ADDR_W){1'b0}}};

    // strap capture waits one edge so the filtered select is valid
    localparam logic [1:0] STRAP_AT = 2'h1;
    localparam logic [1:0] STRAP_DONE = 2'h2;
    localparam logic [1:0] STRAP_STEP = 2'h1;

    // one host access handed to the local bus side
    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] local_addr_data_bus;
        logic [BS_W-1:0] byte_sel;
    } host_req_t;

    localparam int REQ_W = $bits(host_req_t);

    // completion of the local cycle that served a host request
    typedef struct packed {
        logic done;
        logic bus_fault_in;
        logic retry;
        logic [DATA_W-1:0] rd_data;
    } local_resp_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PUSH,
        ST_WAIT,
        ST_DATA,
        ST_STROBE,
        ST_READY
    } port_state_t;

    // widen byte selects into a data mask
    function automatic logic [DATA_W-1:0] byte_mask(input logic [BS_W-1:0] bs);
        logic [DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < BS_W; i++) begin
            m[i*BYTE_W +: BYTE_W] = {BYTE_W{bs[i]}};
        end
        return m;
    endfunction

endpackage

// *** verilog/host_sync.sv ***
// Purpose: three-stage synchroniser with agreement filter for host pins
// Assumes: pins are asynchronous to clk
// Notes:   stage one feeds stage two only; output moves when two and three agree
`timescale 1ns/10ps
module host_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);

    logic [WIDTH-1:0] st1_ff;
    logic [WIDTH-1:0] st2_ff;
    logic [WIDTH-1:0] st3_ff;
    logic [WIDTH-1:0] held_ff;
    logic [WIDTH-1:0] nxt_held;

    // per bit: keep the old value while stages two and three disagree
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_comb begin
            nxt_held[i] = (st2_ff[i] == st3_ff[i]) ? st3_ff[i] : held_ff[i];
        end
    end

    // stages run through reset so the strap level is settled at release
    always_ff @(posedge clk) begin
        st1_ff <= pin_in;
        st2_ff <= st1_ff;
        st3_ff <= st2_ff;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            held_ff <= RST_VAL;
        end else begin
            held_ff <= nxt_held;
        end
    end

    assign pin_out = held_ff;

endmodule // host_sync

// *** verilog/host_fifo.sv ***
// Purpose: request FIFO between the host port and the local bus side
// Assumes: DEPTH is a power of two
// Notes:   output stage is a register, so one extra word can sit in it
`timescale 1ns/10ps
module host_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);
    localparam logic [PW:0] CNT_ONE = (PW + 1)'(1);
    localparam logic [PW-1:0] PTR_ONE = PW'(1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wptr_ff, nxt_wptr, rptr_ff, nxt_rptr;
    logic [PW:0] cnt_ff, nxt_cnt;
    logic out_valid_ff, nxt_out_valid;
    logic [WIDTH-1:0] out_data_ff, nxt_out_data;
    logic push, load;

    // full is honest: nothing enters once every slot holds a word
    assign in_ready = (cnt_ff != FULL_CNT);
    assign push = in_valid && in_ready;
    assign load = (cnt_ff != '0) && (!out_valid_ff || out_ready);

    // pointer, count and output stage next values
    always_comb begin
        nxt_wptr = push ? wptr_ff + PTR_ONE : wptr_ff;
        nxt_rptr = load ? rptr_ff + PTR_ONE : rptr_ff;
        nxt_cnt = cnt_ff;
        if (push && !load) begin
            nxt_cnt = cnt_ff + CNT_ONE;
        end else if (load && !push) begin
            nxt_cnt = cnt_ff - CNT_ONE;
        end
        nxt_out_valid = out_valid_ff;
        nxt_out_data = out_data_ff;
        if (load) begin
            nxt_out_valid = 1'b1;
            nxt_out_data = mem_ff[rptr_ff];
        end else if (out_ready) begin
            nxt_out_valid = 1'b0;
        end
    end

    // storage has no reset; only words behind valid are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
            cnt_ff <= '0;
            out_valid_ff <= 1'b0;
            out_data_ff <= '0;
        end else begin
            wptr_ff <= nxt_wptr;
            rptr_ff <= nxt_rptr;
            cnt_ff <= nxt_cnt;
            out_valid_ff <= nxt_out_valid;
            out_data_ff <= nxt_out_data;
        end
    end

    assign out_valid = out_valid_ff;
    assign out_data = out_data_ff;

endmodule // host_fifo

// *** verilog/host_access_port.sv ***
// Purpose: device end of the host access port: latches host address and
//          byte selects, runs one local access per host strobe, drives
//          ready, data-latch strobe, latch enable and host interrupt
// Assumes: host pins are asynchronous; local side answers each request once
// Notes:   one access in flight at a time; the FIFO lets the local side stall
//
// How it works
// - host address bits 5 to 31 go to bits 0 to 26 of the local bus.
// - byte selects travel with the request and mask the read data.
// - select falling captures the host address and byte selects.
// - access cycles start only while the host select is low.
// - select level after reset picks host-present halt or self-boot.
// - read data is registered and then the data-latch strobe rises.
// - the host interrupt is asserted while the interrupt-out bit is set.
// - a host access ending in bus fault or retry raises the interrupt.
// - host ready is low until the local access has completed.
// - the latch output enable is on while a host write is served.
`timescale 1ns/10ps
module host_access_port #(
    parameter int DEPTH = host_port_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic host_select_n,
    input wire logic host_rd_strobe_n,
    input wire logic host_wr_strobe_n,
    input wire logic [host_port_pkg::BS_W-1:0] host_byte_sel,
    input wire logic [host_port_pkg::ADDR_MSB:host_port_pkg::ADDR_LSB]
        host_long_addr,
    input wire logic irq_out_bit,
    input wire logic fault_clr,
    input wire host_port_pkg::local_resp_t local_resp,
    input wire logic req_ready,
    output logic req_valid,
    output host_port_pkg::host_req_t req,
    output logic host_ready_out,
    output logic host_data_latch_strobe,
    output logic host_latch_oe,
    output logic host_irq_n,
    output logic [host_port_pkg::DATA_W-1:0] host_rd_data,
    output logic host_present,
    output logic boot_start
);

    logic [host_port_pkg::PIN_W-1:0] pins_s;
    logic sel_s, rd_s, wr_s;
    logic [host_port_pkg::BS_W-1:0] bs_s;
    logic [host_port_pkg::ADDR_W-1:0] addr_s;
    logic sel_prev_ff, rd_prev_ff, wr_prev_ff;
    logic sel_fall, rd_fall, wr_rise;
    logic [host_port_pkg::ADDR_W-1:0] lat_addr_ff, nxt_lat_addr;
    logic [host_port_pkg::BS_W-1:0] lat_bs_ff, nxt_lat_bs;
    host_port_pkg::port_state_t state_ff, nxt_state;
    host_port_pkg::host_req_t cur_ff, nxt_cur;
    logic ready_ff, nxt_ready, strobe_ff, nxt_strobe, oe_ff, nxt_oe;
    logic [host_port_pkg::DATA_W-1:0] rd_data_ff, nxt_rd_data;
    logic fault_ff, nxt_fault, fault_hit, irq_n_ff, nxt_irq_n;
    logic [1:0] strap_cnt_ff, nxt_strap_cnt;
    logic present_ff, nxt_present, boot_ff, nxt_boot;
    logic fifo_in_valid, fifo_in_ready;
    logic [host_port_pkg::REQ_W-1:0] fifo_out_data;

    // every host pin crosses into clk before anything looks at it
    host_sync #(
        .WIDTH(host_port_pkg::PIN_W),
        .RST_VAL(host_port_pkg::PIN_IDLE)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .pin_in({host_select_n, host_rd_strobe_n, host_wr_strobe_n,
                 host_byte_sel, host_long_addr}),
        .pin_out(pins_s)
    );

    assign sel_s = pins_s[host_port_pkg::SEL_BIT];
    assign rd_s = pins_s[host_port_pkg::RD_BIT];
    assign wr_s = pins_s[host_port_pkg::WR_BIT];
    assign bs_s = pins_s[host_port_pkg::BS_LSB +: host_port_pkg::BS_W];
    assign addr_s = pins_s[host_port_pkg::ADDR_W-1:0];

    // edges of the filtered strobes
    assign sel_fall = sel_prev_ff && !sel_s;
    assign rd_fall = rd_prev_ff && !rd_s;
    assign wr_rise = !wr_prev_ff && wr_s;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sel_prev_ff <= 1'b1;
            rd_prev_ff <= 1'b1;
            wr_prev_ff <= 1'b1;
        end else begin
            sel_prev_ff <= sel_s;
            rd_prev_ff <= rd_s;
            wr_prev_ff <= wr_s;
        end
    end

    // address latch loads on the select falling edge
    always_comb begin
        nxt_lat_addr = lat_addr_ff;
        nxt_lat_bs = lat_bs_ff;
        if (sel_fall) begin
            nxt_lat_addr = addr_s;
            nxt_lat_bs = bs_s;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lat_addr_ff <= '0;
            lat_bs_ff <= '0;
        end else begin
            lat_addr_ff <= nxt_lat_addr;
            lat_bs_ff <= nxt_lat_bs;
        end
    end

    // access sequencer; a strobe that comes with select falling uses the
    // fresh pins, since the latch only shows them one edge later
    always_comb begin
        nxt_state = state_ff;
        nxt_cur = cur_ff;
        nxt_rd_data = rd_data_ff;
        case (state_ff)
            host_port_pkg::ST_IDLE: begin
                // both strobes low is illegal and starts nothing
                if (!sel_s && (rd_fall && wr_s) != (wr_rise && rd_s)) begin
                    nxt_cur.write = wr_rise;
                    nxt_cur.local_addr_data_bus =
                        sel_fall ? addr_s : lat_addr_ff;
                    nxt_cur.byte_sel = sel_fall ? bs_s : lat_bs_ff;
                    nxt_state = host_port_pkg::ST_PUSH;
                end
            end
            host_port_pkg::ST_PUSH: begin
                if (fifo_in_ready) begin
                    nxt_state = host_port_pkg::ST_WAIT;
                end
            end
            host_port_pkg::ST_WAIT: begin
                if (local_resp.done) begin
                    nxt_rd_data = local_resp.rd_data &
                        host_port_pkg::byte_mask(cur_ff.byte_sel);
                    nxt_state = cur_ff.write ? host_port_pkg::ST_READY
                                             : host_port_pkg::ST_DATA;
                end
            end
            host_port_pkg::ST_DATA: begin
                nxt_state = host_port_pkg::ST_STROBE; // data settles first
            end
            host_port_pkg::ST_STROBE: begin
                nxt_state = host_port_pkg::ST_READY;
            end
            host_port_pkg::ST_READY: begin
                // a read ends when the host lifts its read strobe
                if (sel_s || (!cur_ff.write && rd_s)) begin
                    nxt_state = host_port_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = host_port_pkg::ST_IDLE;
            end
        endcase
    end

    // pin outputs follow the next state so they change with it
    always_comb begin
        nxt_ready = (nxt_state == host_port_pkg::ST_READY);
        nxt_strobe = !nxt_cur.write &&
            (nxt_state == host_port_pkg::ST_STROBE ||
             nxt_state == host_port_pkg::ST_READY);
        nxt_oe = nxt_cur.write &&
            (nxt_state == host_port_pkg::ST_PUSH ||
             nxt_state == host_port_pkg::ST_WAIT);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_ff <= host_port_pkg::ST_IDLE;
            cur_ff <= '0;
            rd_data_ff <= '0;
            ready_ff <= 1'b0;
            strobe_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cur_ff <= nxt_cur;
            rd_data_ff <= nxt_rd_data;
            ready_ff <= nxt_ready;
            strobe_ff <= nxt_strobe;
            oe_ff <= nxt_oe;
        end
    end

    // fault flag: a new fault beats a clear in the same cycle
    assign fault_hit = (state_ff == host_port_pkg::ST_WAIT) && local_resp.done &&
        (local_resp.bus_fault_in || local_resp.retry);

    always_comb begin
        nxt_fault = fault_hit ? 1'b1 : (fault_clr ? 1'b0 : fault_ff);
        nxt_irq_n = !(irq_out_bit || nxt_fault);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fault_ff <= 1'b0;
            irq_n_ff <= 1'b1;
        end else begin
            fault_ff <= nxt_fault;
            irq_n_ff <= nxt_irq_n;
        end
    end

    // start mode strap, taken from the filtered select after release
    always_comb begin
        nxt_strap_cnt = strap_cnt_ff;
        nxt_present = present_ff;
        nxt_boot = 1'b0;
        if (strap_cnt_ff != host_port_pkg::STRAP_DONE) begin
            nxt_strap_cnt = strap_cnt_ff + host_port_pkg::STRAP_STEP;
        end
        if (strap_cnt_ff == host_port_pkg::STRAP_AT) begin
            nxt_present = sel_s;
            nxt_boot = !sel_s;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            strap_cnt_ff <= '0;
            present_ff <= 1'b0;
            boot_ff <= 1'b0;
        end else begin
            strap_cnt_ff <= nxt_strap_cnt;
            present_ff <= nxt_present;
            boot_ff <= nxt_boot;
        end
    end

    // requests queue here; a stalled local side holds the sequencer in wait
    assign fifo_in_valid = (state_ff == host_port_pkg::ST_PUSH);

    host_fifo #(
        .WIDTH(host_port_pkg::REQ_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(cur_ff),
        .out_valid(req_valid),
        .out_ready(req_ready),
        .out_data(fifo_out_data)
    );

    assign req = fifo_out_data;
    assign host_ready_out = ready_ff;
    assign host_data_latch_strobe = strobe_ff;
    assign host_latch_oe = oe_ff;
    assign host_irq_n = irq_n_ff;
    assign host_rd_data = rd_data_ff;
    assign host_present = present_ff;
    assign boot_start = boot_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_addr_map_push: assert property (
        (state_ff == host_port_pkg::ST_IDLE &&
         nxt_state == host_port_pkg::ST_PUSH) |=>
        cur_ff.local_addr_data_bus == lat_addr_ff &&
        cur_ff.byte_sel == lat_bs_ff)
        else $error("request address differs from latched host address");
    chk_read_byte_mask: assert property (
        strobe_ff |-> (rd_data_ff & ~host_port_pkg::byte_mask(cur_ff.byte_sel))
        == '0)
        else $error("unselected read byte not zero");
    chk_addr_latch: assert property (
        sel_fall |=> lat_addr_ff == $past(addr_s) && lat_bs_ff == $past(bs_s))
        else $error("address latch missed select edge");
    chk_no_start_unsel: assert property (
        (state_ff == host_port_pkg::ST_IDLE && sel_s) |=>
        state_ff == host_port_pkg::ST_IDLE)
        else $error("access started without select");
    chk_strap_mode: assert property (
        strap_cnt_ff == host_port_pkg::STRAP_AT |=>
        present_ff == $past(sel_s) && boot_ff == !$past(sel_s) ##1 !boot_ff)
        else $error("start mode not taken from select");
    chk_strobe_after_data: assert property (
        $rose(strobe_ff) |-> !cur_ff.write &&
        $past(state_ff) == host_port_pkg::ST_DATA && $stable(rd_data_ff))
        else $error("data strobe rose without settled data");
    chk_irq_follows_bit: assert property (
        irq_out_bit |=> !irq_n_ff)
        else $error("interrupt bit set but host interrupt idle");
    chk_fault_irq: assert property (
        fault_hit |=> !irq_n_ff && fault_ff)
        else $error("faulted access did not interrupt host");
    chk_ready_after_done: assert property (
        $rose(ready_ff) |-> $past(state_ff) == host_port_pkg::ST_STROBE ||
        ($past(state_ff) == host_port_pkg::ST_WAIT && $past(local_resp.done)))
        else $error("host ready rose before local completion");
    chk_oe_write_only: assert property (
        oe_ff == (cur_ff.write && (state_ff == host_port_pkg::ST_PUSH ||
        state_ff == host_port_pkg::ST_WAIT)))
        else $error("latch enable wrong for access direction");
    chk_irq_release: assert property (
        (!irq_out_bit && !fault_hit && (!fault_ff || fault_clr)) |=> irq_n_ff)
        else $error("host interrupt held after sources cleared");

endmodule // host_access_port

// *** testbench/local_side_model.sv ***
// Purpose: behavioural local bus side that serves host port requests
// Assumes: one request served at a time, answer after a chosen delay
// Notes:   read data outside the done cycle toggles every cycle, so a
//          sampler that looks at the wrong cycle sees garbage
`timescale 1ns/10ps
module local_side_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire host_port_pkg::host_req_t req,
    output logic req_ready,
    output host_port_pkg::local_resp_t local_resp,
    input wire logic [3:0] resp_delay,
    input wire logic resp_fault,
    input wire logic resp_retry,
    input wire logic [31:0] resp_data
);
    logic busy = 1'b0;
    logic [3:0] cnt = 4'h0;
    logic [31:0] junk = 32'h5555_aaaa;

    // stall the request stream while an access is outstanding
    assign req_ready = !busy;

    // accept, count down the wait, then give one done pulse
    always @(posedge clk) begin
        junk <= ~junk;
        local_resp <= '{1'b0, 1'b0, 1'b0, junk};
        if (!rst_b) begin
            busy <= 1'b0;
        end else if (!busy && req_valid) begin
            busy <= 1'b1;
            cnt <= resp_delay;
        end else if (busy && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (busy) begin
            busy <= 1'b0;
            local_resp <= '{1'b1, resp_fault, resp_retry, resp_data};
        end
    end
endmodule // local_side_model

// *** testbench/tb_host_access_port.sv ***
// Purpose: self-checking bench of the host access port
// Assumes: host pins pass a slow synchroniser, so host steps are spaced
// Notes:   table rows cover reads, writes, faults; strap checks come before
//          and after the table, refusals are hand-written after it
`timescale 1ns/10ps
module tb_host_access_port;
    typedef struct packed {
        logic wr;
        logic [26:0] addr;
        logic [3:0] bs;
        logic [31:0] data;
        logic flt;
        logic rty;
        logic [3:0] dly;
        logic [31:0] exp_rd;
        logic exp_irq_n;
    } row_t;

    localparam row_t ROWS [0:5] = '{
        '{1'b0, 27'h000_0001, 4'hf, 32'h1234_5678, 1'b0, 1'b0, 4'h0,
          32'h1234_5678, 1'b1},
        '{1'b1, 27'h7ff_ffff, 4'h5, 32'h0000_0000, 1'b0, 1'b0, 4'h3,
          32'h0000_0000, 1'b1},
        '{1'b0, 27'h2aa_5555, 4'h6, 32'hdead_beef, 1'b0, 1'b0, 4'h5,
          32'h00ad_be00, 1'b1},
        '{1'b0, 27'h555_aaaa, 4'h1, 32'hcafe_f00d, 1'b1, 1'b0, 4'h1,
          32'h0000_000d, 1'b0},
        '{1'b1, 27'h000_0100, 4'hc, 32'h0000_0000, 1'b0, 1'b1, 4'h2,
          32'h0000_0000, 1'b0},
        '{1'b0, 27'h400_0000, 4'h8, 32'ha5c3_0f1e, 1'b0, 1'b0, 4'hf,
          32'ha500_0000, 1'b1}};

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic host_select_n = 1'b1;
    logic host_rd_strobe_n = 1'b1;
    logic host_wr_strobe_n = 1'b1;
    logic [3:0] host_byte_sel = 4'h0;
    logic [31:5] host_long_addr = 27'h000_0000;
    logic irq_out_bit = 1'b0;
    logic fault_clr = 1'b0;
    host_port_pkg::local_resp_t local_resp;
    logic req_ready;
    logic req_valid;
    host_port_pkg::host_req_t req;
    host_port_pkg::host_req_t seen_req;
    logic host_ready_out;
    logic host_data_latch_strobe;
    logic host_latch_oe;
    logic host_irq_n;
    logic [31:0] host_rd_data;
    logic host_present;
    logic boot_start;
    logic [3:0] resp_delay = 4'h0;
    logic resp_fault = 1'b0;
    logic resp_retry = 1'b0;
    logic [31:0] resp_data = 32'h0000_0000;
    logic oe_seen = 1'b0;
    int failures = 0;
    int total_checks = 0;
    int req_cnt = 0;
    int boot_cnt = 0;
    int held;

    always #2.5 clk = ~clk;

    host_access_port uut (.clk(clk), .rst_b(rst_b),
        .host_select_n(host_select_n), .host_rd_strobe_n(host_rd_strobe_n),
        .host_wr_strobe_n(host_wr_strobe_n), .host_byte_sel(host_byte_sel),
        .host_long_addr(host_long_addr), .irq_out_bit(irq_out_bit),
        .fault_clr(fault_clr), .local_resp(local_resp),
        .req_ready(req_ready), .req_valid(req_valid), .req(req),
        .host_ready_out(host_ready_out),
        .host_data_latch_strobe(host_data_latch_strobe),
        .host_latch_oe(host_latch_oe), .host_irq_n(host_irq_n),
        .host_rd_data(host_rd_data), .host_present(host_present),
        .boot_start(boot_start));

    local_side_model partner (.clk(clk), .rst_b(rst_b),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .local_resp(local_resp), .resp_delay(resp_delay),
        .resp_fault(resp_fault), .resp_retry(resp_retry),
        .resp_data(resp_data));

    // watch handshakes, latch enable and boot pulses at the ports
    always @(posedge clk) begin
        if (req_valid === 1'b1 && req_ready === 1'b1) begin
            seen_req <= req;
            req_cnt <= req_cnt + 1;
        end
        if (host_latch_oe === 1'b1) oe_seen <= 1'b1;
        if (boot_start === 1'b1) boot_cnt <= boot_cnt + 1;
    end

    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // bounded wait for host ready; a hang ends the run
    task automatic wait_ready(input logic lvl);
        int n;
        n = 0;
        while (host_ready_out !== lvl) begin
            @(posedge clk);
            n++;
            if (n > 200) begin
                failures++;
                $display("BAD host_ready_out wait timed out");
                final_report();
            end
        end
    endtask

    // reset with the select strap at the given level
    task automatic do_reset(input logic sel);
        @(posedge clk);
        rst_b <= 1'b0;
        host_select_n <= sel;
        boot_cnt = 0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (12) @(posedge clk);
    endtask

    // one host access; address pins change after select to prove the latch
    task automatic host_cycle(input row_t r);
        @(posedge clk);
        resp_delay <= r.dly;
        resp_fault <= r.flt;
        resp_retry <= r.rty;
        resp_data <= r.data;
        host_long_addr <= r.addr;
        host_byte_sel <= r.bs;
        host_select_n <= 1'b0;
        oe_seen = 1'b0;
        repeat (6) @(posedge clk);
        host_long_addr <= ~r.addr;
        host_byte_sel <= ~r.bs;
        if (r.wr) host_wr_strobe_n <= 1'b0;
        else host_rd_strobe_n <= 1'b0;
        repeat (6) @(posedge clk);
        host_wr_strobe_n <= 1'b1;
        wait_ready(1'b1);
        #1;
        check("req_addr", seen_req.local_addr_data_bus, r.addr);
        check("req_bs", seen_req.byte_sel, r.bs);
        check("req_wr", seen_req.write, r.wr);
        check("latch_oe", oe_seen, r.wr);
        if (!r.wr) begin
            check("dstrobe", host_data_latch_strobe, 1'b1);
            check("rd_data", host_rd_data, r.exp_rd);
        end
        check("irq_fault", host_irq_n, r.exp_irq_n);
        @(posedge clk);
        host_rd_strobe_n <= 1'b1;
        host_select_n <= 1'b1;
        fault_clr <= 1'b1;
        @(posedge clk);
        fault_clr <= 1'b0;
        wait_ready(1'b0);
        repeat (3) @(posedge clk);
        check("irq_clear", host_irq_n, 1'b1);
    endtask

    // strobes that must start nothing
    task automatic refused(input logic sel, input logic wr_n);
        held = req_cnt;
        @(posedge clk);
        host_select_n <= sel;
        host_rd_strobe_n <= 1'b0;
        host_wr_strobe_n <= wr_n;
        repeat (20) @(posedge clk);
        host_wr_strobe_n <= 1'b1;
        repeat (6) @(posedge clk);
        check("refused_req", req_cnt - held, 32'h0000_0000);
        check("refused_rdy", host_ready_out, 1'b0);
        host_rd_strobe_n <= 1'b1;
        host_select_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask

    initial begin
        do_reset(1'b1);
        check("present_hi", host_present, 1'b1);
        check("boot_hi", boot_cnt, 32'h0000_0000);
        foreach (ROWS[i]) begin
            host_cycle(ROWS[i]);
        end
        refused(1'b1, 1'b1);
        refused(1'b0, 1'b0);
        // select and read fall together: the fresh pins feed the request
        @(posedge clk);
        host_long_addr <= ROWS[2].addr;
        host_byte_sel <= ROWS[2].bs;
        host_select_n <= 1'b0;
        host_rd_strobe_n <= 1'b0;
        wait_ready(1'b1);
        check("both_addr", seen_req.local_addr_data_bus,
            ROWS[2].addr);
        check("both_rd", host_rd_data, 32'h00c3_0f00);
        check("both_strobe", host_data_latch_strobe, 1'b1);
        host_rd_strobe_n <= 1'b1;
        host_select_n <= 1'b1;
        wait_ready(1'b0);
        // interrupt-out bit drives the host interrupt both ways
        irq_out_bit <= 1'b1;
        repeat (3) @(posedge clk);
        check("irq_bit_on", host_irq_n, 1'b0);
        irq_out_bit <= 1'b0;
        repeat (3) @(posedge clk);
        check("irq_bit_off", host_irq_n, 1'b1);
        // second reset with select low: self-boot, one start pulse
        do_reset(1'b0);
        check("present_lo", host_present, 1'b0);
        check("boot_lo", boot_cnt, 32'h0000_0001);
        host_select_n <= 1'b1;
        repeat (8) @(posedge clk);
        host_cycle(ROWS[0]);
        final_report();
    end
endmodule // tb_host_access_port
